// [rtl/ecc_cond.sv]
// encoder and phase current conditioning: calibration, path select, monitors
// Function
// (R1) v encoder input stage code in config bits 27:24, eight codes
// (R2) w encoder input stage code in config bits 31:28, same codes
// (R3) channel 0 calibration holds unsigned offset in bits 15:0
// (R4) channel 0 calibration holds signed scale in bits 31:16
// (R5) channel 1 has its own calibration register, same layout
// (R6) channel 2 has its own calibration register, same layout
// (R7) each path applies its own offset and scale correction
// (R8) three 8-bit selectors pick u, v or w raw sample per path
// (R9) any physical channel may feed any path to undo wiring swaps
// (R10) monitor shows corrected u current low, w current high
// (R11) second monitor shows corrected v current low half
// (R12) monitored currents are scaled, offset, correctly assigned samples
// (R13) monitor values are exactly the values sent to field control
// (R14) monitor shows corrected u and w encoder signals
// (R15) input stage codes live in the input stage config register
// (R16) corrected encoder values are forwarded to the interpolator
// (R17) monitor registers are read-only; writes are ignored
// (R18) selector codes above 2 are reserved, route undefined
`include "ecc_cfg.svh"

module ecc_cond (
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     resetn_i,
  // register port
  input  wire logic [`ECC_ADDR_W-1:0]   reg_addr_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [31:0]              reg_wdata_i,
  input  wire logic                     reg_rd_i,
  output logic      [31:0]              reg_rdata_o,
  output logic                          reg_rvalid_o,
  // raw encoder adc samples
  input  wire logic                     enc_valid_i,
  input  wire ecc_pkg::ecc_u16_t        encoder_u_raw_sample_i,
  input  wire ecc_pkg::ecc_u16_t        encoder_v_raw_sample_i,
  input  wire ecc_pkg::ecc_u16_t        encoder_w_raw_sample_i,
  // corrected phase currents from the current scaling stage
  input  wire logic                     cur_valid_i,
  input  wire ecc_pkg::ecc_s16_t        phase_u_current_i,
  input  wire ecc_pkg::ecc_s16_t        phase_v_current_i,
  input  wire ecc_pkg::ecc_s16_t        phase_w_current_i,
  // input stage selection to the adc front end
  output ecc_pkg::ecc_stage_t           encoder_v_input_stage_o,
  output ecc_pkg::ecc_stage_t           encoder_w_input_stage_o,
  // to the interpolator
  output logic                          interp_valid_o,
  output ecc_pkg::ecc_s16_t             interp_u_o,
  output ecc_pkg::ecc_s16_t             interp_v_o,
  output ecc_pkg::ecc_s16_t             interp_w_o,
  // to field oriented control
  output logic                          foc_valid_o,
  output ecc_pkg::ecc_s16_t             foc_u_o,
  output ecc_pkg::ecc_s16_t             foc_v_o,
  output ecc_pkg::ecc_s16_t             foc_w_o
);
  import ecc_pkg::*;

  logic [3:0]         stg_v_q;
  logic [3:0]         stg_w_q;
  logic [31:0]        cal_q [3];
  logic [23:0]        sel_q;
  ecc_u16_t           path_raw [3];
  ecc_s16_t           corr [3];
  ecc_s16_t           enc_q [3];
  logic               enc_vld_q;
  ecc_s16_t           cur_q [3];
  logic               cur_vld_q;
  logic [31:0]        rdata_q;
  logic               rvalid_q;
  logic               wr_stage;
  logic               wr_sel;

  assign wr_stage = reg_wr_i && (reg_addr_i == `ECC_IDX_STAGE);
  assign wr_sel   = reg_wr_i && (reg_addr_i == `ECC_IDX_SEL);

  // input stage config; other front-end fields are outside this block
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stg_v_q <= `ECC_RST_STAGE;
      stg_w_q <= `ECC_RST_STAGE;
    end else if (wr_stage) begin // R15
      stg_v_q <= reg_wdata_i[`ECC_STG_V_LSB +: 4]; // R1
      stg_w_q <= reg_wdata_i[`ECC_STG_W_LSB +: 4]; // R2
    end
  end

  assign encoder_v_input_stage_o = ecc_stage_t'(stg_v_q);
  assign encoder_w_input_stage_o = ecc_stage_t'(stg_w_q);

  // path selectors; identity mapping after reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_q <= `ECC_RST_SEL;
    end else if (wr_sel) begin
      sel_q <= reg_wdata_i[23:0]; // R8
    end
  end

  genvar g;
  for (g = 0; g < 3; g++) begin : g_path
    localparam logic [`ECC_ADDR_W-1:0] CAL_IDX = 7'(`ECC_IDX_CAL0 + g);
    logic [7:0]          sel;
    logic signed [16:0]  diff;
    logic signed [32:0]  prod;
    logic signed [32:0]  shr;

    assign sel = sel_q[g*`ECC_SEL_W +: `ECC_SEL_W];

    // calibration word per channel
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cal_q[g] <= {`ECC_RST_SCALE, `ECC_RST_OFS};
      end else if (reg_wr_i && (reg_addr_i == CAL_IDX)) begin
        cal_q[g] <= reg_wdata_i; // R3 R4 R5 R6
      end
    end

    // any source onto any path; reserved codes feed zero
    always_comb begin
      case (sel)
        ECC_SRC_U: path_raw[g] = encoder_u_raw_sample_i; // R9
        ECC_SRC_V: path_raw[g] = encoder_v_raw_sample_i;
        ECC_SRC_W: path_raw[g] = encoder_w_raw_sample_i;
        default:   path_raw[g] = 16'h0000; // R18
      endcase
    end

    // offset removal, then signed scale with saturation
    always_comb begin
      diff = $signed({1'b0, path_raw[g]}) - $signed({1'b0, cal_q[g][`ECC_OFS_LSB +: 16]});
      prod = diff * $signed(cal_q[g][`ECC_SCL_LSB +: 16]); // R7
      shr  = prod >>> `ECC_SCALE_SHIFT;
      if (shr > $signed({17'h00000, `ECC_SAT_MAX})) begin
        corr[g] = `ECC_SAT_MAX;
      end else if (shr < $signed({17'h1FFFF, `ECC_SAT_MIN})) begin
        corr[g] = `ECC_SAT_MIN;
      end else begin
        corr[g] = shr[15:0];
      end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        enc_q[g] <= 16'h0000;
      end else if (enc_valid_i) begin
        enc_q[g] <= corr[g]; // R16
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enc_vld_q <= 1'b0;
    end else begin
      enc_vld_q <= enc_valid_i;
    end
  end

  assign interp_valid_o = enc_vld_q;
  assign interp_u_o     = enc_q[0]; // R16
  assign interp_v_o     = enc_q[1];
  assign interp_w_o     = enc_q[2];

  // one register set serves both monitor and control, so they never differ
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_q[0]  <= 16'h0000;
      cur_q[1]  <= 16'h0000;
      cur_q[2]  <= 16'h0000;
      cur_vld_q <= 1'b0;
    end else begin
      cur_vld_q <= cur_valid_i;
      if (cur_valid_i) begin
        cur_q[0] <= phase_u_current_i; // R12
        cur_q[1] <= phase_v_current_i;
        cur_q[2] <= phase_w_current_i;
      end
    end
  end

  assign foc_valid_o = cur_vld_q;
  assign foc_u_o     = cur_q[0]; // R13
  assign foc_v_o     = cur_q[1];
  assign foc_w_o     = cur_q[2];

  // read port; monitors have no write path at all
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ECC_IDX_STAGE:   rdata_q <= {stg_w_q, stg_v_q, 24'h000000};
          `ECC_IDX_CAL0:    rdata_q <= cal_q[0];
          `ECC_IDX_CAL1:    rdata_q <= cal_q[1];
          `ECC_IDX_CAL2:    rdata_q <= cal_q[2];
          `ECC_IDX_SEL:     rdata_q <= {8'h00, sel_q};
          `ECC_IDX_MON_IUW: rdata_q <= {cur_q[2], cur_q[0]}; // R10
          `ECC_IDX_MON_IV:  rdata_q <= {16'h0000, cur_q[1]}; // R11
          `ECC_IDX_MON_ENC: rdata_q <= {enc_q[2], enc_q[0]}; // R14
          default:          rdata_q <= 32'h0000_0000; // R17
        endcase
      end
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_stage_v;
    wr_stage |=> encoder_v_input_stage_o == $past(reg_wdata_i[27:24]);
  endproperty
  a_stage_v: assert property (p_stage_v) else $error("v input stage not taken"); // R1

  property p_stage_w;
    wr_stage ##1 !wr_stage |=> encoder_w_input_stage_o == $past(reg_wdata_i[31:28], 2);
  endproperty
  a_stage_w: assert property (p_stage_w) else $error("w input stage not held"); // R2

  property p_cal0_ofs;
    reg_wr_i && reg_addr_i == `ECC_IDX_CAL0 ##1 reg_rd_i && reg_addr_i == `ECC_IDX_CAL0
      |=> reg_rdata_o[15:0] == $past(reg_wdata_i[15:0], 2);
  endproperty
  a_cal0_ofs: assert property (p_cal0_ofs) else $error("ch0 offset readback wrong"); // R3

  property p_cal0_scl;
    reg_wr_i && reg_addr_i == `ECC_IDX_CAL0 |=> cal_q[0][31:16] == $past(reg_wdata_i[31:16]);
  endproperty
  a_cal0_scl: assert property (p_cal0_scl) else $error("ch0 scale not stored"); // R4

  property p_cal1;
    reg_wr_i && reg_addr_i == `ECC_IDX_CAL1 |=> cal_q[1] == $past(reg_wdata_i) && $stable(cal_q[0]);
  endproperty
  a_cal1: assert property (p_cal1) else $error("ch1 calibration wrong"); // R5

  property p_cal2;
    reg_wr_i && reg_addr_i == `ECC_IDX_CAL2 |=> cal_q[2] == $past(reg_wdata_i) && $stable(cal_q[1]);
  endproperty
  a_cal2: assert property (p_cal2) else $error("ch2 calibration wrong"); // R6

  property p_unity;
    enc_valid_i && sel_q[7:0] == 8'h00 && cal_q[0] == 32'h0100_0000 && !encoder_u_raw_sample_i[15]
      |=> interp_u_o == $past(encoder_u_raw_sample_i) && interp_valid_o;
  endproperty
  a_unity: assert property (p_unity) else $error("unity correction not transparent"); // R7

  property p_route_v;
    sel_q[15:8] == 8'h02 |-> path_raw[1] == encoder_w_raw_sample_i;
  endproperty
  a_route_v: assert property (p_route_v) else $error("path 1 not fed from w"); // R9

  property p_route_u;
    sel_q[7:0] == 8'h01 |-> path_raw[0] == encoder_v_raw_sample_i;
  endproperty
  a_route_u: assert property (p_route_u) else $error("path 0 not fed from v"); // R8

  property p_reserved;
    sel_q[23:16] > 8'h02 |-> path_raw[2] == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not zeroed"); // R18

  property p_mon_iuw;
    reg_rd_i && reg_addr_i == `ECC_IDX_MON_IUW && !cur_valid_i
      |=> reg_rvalid_o && reg_rdata_o == {foc_w_o, foc_u_o};
  endproperty
  a_mon_iuw: assert property (p_mon_iuw) else $error("u/w current monitor wrong"); // R10

  property p_mon_iv;
    reg_rd_i && reg_addr_i == `ECC_IDX_MON_IV && !cur_valid_i
      |=> reg_rdata_o == {16'h0000, foc_v_o};
  endproperty
  a_mon_iv: assert property (p_mon_iv) else $error("v current monitor wrong"); // R11

  property p_foc;
    cur_valid_i |=> foc_valid_o && foc_u_o == $past(phase_u_current_i)
      && foc_w_o == $past(phase_w_current_i);
  endproperty
  a_foc: assert property (p_foc) else $error("control currents not forwarded"); // R13

  property p_mon_enc;
    reg_rd_i && reg_addr_i == `ECC_IDX_MON_ENC && !enc_valid_i
      |=> reg_rdata_o == {interp_w_o, interp_u_o};
  endproperty
  a_mon_enc: assert property (p_mon_enc) else $error("encoder monitor wrong"); // R14

  property p_ro;
    reg_wr_i && reg_addr_i inside {`ECC_IDX_MON_IUW, `ECC_IDX_MON_IV, `ECC_IDX_MON_ENC}
      && !enc_valid_i && !cur_valid_i |=> $stable(foc_u_o) && $stable(interp_u_o) && $stable(sel_q);
  endproperty
  a_ro: assert property (p_ro) else $error("write to monitor had effect"); // R17

  // the v current monitor word is only compared with foc_v_o, so its routing to its phase is checked on the control port
  property p_cur_v;
    cur_valid_i |=> foc_v_o == $past(phase_v_current_i);
  endproperty
  a_cur_v: assert property (p_cur_v) else $error("v current not routed to its phase"); // R12

  property p_interp_hold;
    !enc_valid_i |=> !interp_valid_o && $stable(interp_u_o) && $stable(interp_v_o) && $stable(interp_w_o);
  endproperty
  a_interp_hold: assert property (p_interp_hold) else $error("interpolator input moved without a sample"); // R16

endmodule

// [include/ecc_cfg.svh]
// register indices, field positions, reset values of the encoder/current conditioning block
`ifndef ECC_CFG_SVH
`define ECC_CFG_SVH
`define ECC_ADDR_W       7
`define ECC_IDX_STAGE    7'h0C
`define ECC_IDX_CAL0     7'h0D
`define ECC_IDX_CAL1     7'h0E
`define ECC_IDX_CAL2     7'h0F
`define ECC_IDX_SEL      7'h11
`define ECC_IDX_MON_IUW  7'h12
`define ECC_IDX_MON_IV   7'h13
`define ECC_IDX_MON_ENC  7'h15
`define ECC_STG_V_LSB    24
`define ECC_STG_W_LSB    28
`define ECC_OFS_LSB      0
`define ECC_SCL_LSB      16
`define ECC_SEL_W        8
`define ECC_SCALE_SHIFT  8
`define ECC_RST_STAGE    4'h0
`define ECC_RST_OFS      16'h0000
`define ECC_RST_SCALE    16'h0100
`define ECC_RST_SEL      24'h020100
`define ECC_SAT_MAX      16'h7FFF
`define ECC_SAT_MIN      16'h8000
`endif

// [include/ecc_pkg.sv]
// types of the encoder/current conditioning block
package ecc_pkg;
  typedef logic signed [15:0] ecc_s16_t;
  typedef logic [15:0]        ecc_u16_t;
  // input stage codes, in code order 0..7
  typedef enum logic [3:0] {
    ECC_STG_DIFF, ECC_STG_GND_NEG, ECC_STG_QTR, ECC_STG_3QTR,
    ECC_STG_POS_GND, ECC_STG_HALF, ECC_STG_QTR_B, ECC_STG_3QTR_B
  } ecc_stage_t;
  // raw path source codes; codes above 2 are reserved
  typedef enum logic [7:0] {
    ECC_SRC_U, ECC_SRC_V, ECC_SRC_W
  } ecc_src_t;
endpackage

// [test/ecc_adc_model.sv]
// behavioural adc front end: raw encoder samples and phase currents
module ecc_adc_model #(
  parameter logic [15:0] SEED = 16'h00C9
) (
  // clock and run control
  input  wire logic         sys_clk_i,
  input  wire logic         run_i,
  // raw encoder samples
  output logic              enc_valid_o,
  output ecc_pkg::ecc_u16_t enc_u_o,
  output ecc_pkg::ecc_u16_t enc_v_o,
  output ecc_pkg::ecc_u16_t enc_w_o,
  // corrected phase currents
  output logic              cur_valid_o,
  output ecc_pkg::ecc_s16_t cur_u_o,
  output ecc_pkg::ecc_s16_t cur_v_o,
  output ecc_pkg::ecc_s16_t cur_w_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import ecc_pkg::*;
  logic [15:0] s_q = SEED;
  logic [1:0]  v_q = 2'h0;
  // data moves every cycle, valid or not, so a stale sample never looks fresh
  always @(negedge sys_clk_i) begin
    s_q <= {s_q[14:0], s_q[15] ^ s_q[13] ^ s_q[12] ^ s_q[10]};
    v_q <= s_q[3:2];
  end
  assign enc_valid_o = run_i & v_q[0];
  assign cur_valid_o = run_i & v_q[1];
  assign enc_u_o     = s_q;
  assign enc_v_o     = {s_q[7:0], s_q[15:8]};
  assign enc_w_o     = ~s_q;
  assign cur_u_o     = s_q ^ 16'h5A5A;
  assign cur_v_o     = {s_q[3:0], s_q[15:4]};
  assign cur_w_o     = -s_q;
endmodule

// [test/ecc_cond_tb_top.sv]
// self-checking bench of the encoder and current conditioning block
`include "ecc_cfg.svh"
module ecc_cond_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ecc_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [6:0]  reg_addr_i = 7'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        run = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic        reg_rvalid_o, enc_valid_i, cur_valid_i, interp_valid_o, foc_valid_o;
  ecc_u16_t    eu, ev, ew;
  ecc_s16_t    cu, cv, cw, iu, iv, iw, fu, fv, fw;
  ecc_s16_t    eexp[3] = '{3{16'h0}};
  ecc_s16_t    cexp[3] = '{3{16'h0}};
  ecc_stage_t  stg_v, stg_w;
  logic [31:0] cal[3] = '{3{32'h0100_0000}};
  logic [31:0] sel = 32'h0002_0100;
  logic [31:0] tbl[5] = '{32'h0002_0100, 32'h0000_0102, 32'h0001_0200, 32'h0000_0101, 32'h0003_0201};
  logic [15:0] seed = 16'h00C9;
  logic        e_pend = 1'b0;
  logic        c_pend = 1'b0;
  int          fail_count = 0;
  int          cmp_count = 0;

  ecc_adc_model #(.SEED(16'h00C9)) adc (.sys_clk_i, .run_i(run), .enc_valid_o(enc_valid_i), .enc_u_o(eu),
    .enc_v_o(ev), .enc_w_o(ew), .cur_valid_o(cur_valid_i), .cur_u_o(cu), .cur_v_o(cv), .cur_w_o(cw));
  ecc_cond dut (.sys_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .enc_valid_i, .encoder_u_raw_sample_i(eu), .encoder_v_raw_sample_i(ev),
    .encoder_w_raw_sample_i(ew), .cur_valid_i, .phase_u_current_i(cu), .phase_v_current_i(cv),
    .phase_w_current_i(cw), .encoder_v_input_stage_o(stg_v), .encoder_w_input_stage_o(stg_w),
    .interp_valid_o, .interp_u_o(iu), .interp_v_o(iv), .interp_w_o(iw), .foc_valid_o, .foc_u_o(fu),
    .foc_v_o(fv), .foc_w_o(fw));

  always #12.5 sys_clk_i = ~sys_clk_i;

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic ecc_u16_t pick(input logic [7:0] c);
    return (c == 8'h00) ? eu : (c == 8'h01) ? ev : (c == 8'h02) ? ew : 16'h0000;
  endfunction
  // offset removed first, then gain with 8 fraction bits, then clamp
  function automatic ecc_s16_t corr(input ecc_u16_t raw, input logic [31:0] c);
    logic signed [47:0] p;
    p = (($signed({1'b0, raw}) - $signed({1'b0, c[15:0]})) * $signed(c[31:16])) >>> 8;
    return (p > 32767) ? 16'h7FFF : (p < -32768) ? 16'h8000 : p[15:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    chk({31'h0, reg_rvalid_o}, 32'h1);
    chk(reg_rdata_o, exp);
  endtask
  // write then read back on the very next cycle, which the port allows
  task automatic wrrd(input logic [6:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    chk({31'h0, reg_rvalid_o}, 32'h1);
    chk(reg_rdata_o, d);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // expectations use the calibration in force at the sampling edge
  always @(posedge sys_clk_i) begin
    e_pend <= enc_valid_i;
    c_pend <= cur_valid_i;
    if (enc_valid_i) for (int g = 0; g < 3; g++) eexp[g] <= corr(pick(sel[8*g +: 8]), cal[g]);
    if (cur_valid_i) cexp <= '{cu, cv, cw};
  end
  always @(negedge sys_clk_i) begin
    chk({30'h0, interp_valid_o, foc_valid_o}, {30'h0, e_pend, c_pend});
    if (e_pend) chk({iu, iv}, {eexp[0], eexp[1]});
    if (e_pend) chk({16'h0, iw}, {16'h0, eexp[2]});
    if (c_pend) chk({fu, fv}, {cexp[0], cexp[1]});
    if (c_pend) chk({16'h0, fw}, {16'h0, cexp[2]});
  end

  initial begin
    #(3000 * 25);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    for (int g = 0; g < 3; g++) rd(`ECC_IDX_CAL0 + 7'(g), cal[g]);
    rd(`ECC_IDX_SEL, sel);
    wr(7'h10, 32'hFFFF_FFFF);
    rd(7'h10, 32'h0);
    // junk in the reserved low bits must read back as zero
    for (int i = 0; i < 8; i++) begin
      seed = nxt(seed);
      wr(`ECC_IDX_STAGE, {4'(7 - i), 4'(i), 8'hA5, seed});
      chk({24'h0, stg_w, stg_v}, {24'h0, 4'(7 - i), 4'(i)});
      rd(`ECC_IDX_STAGE, {4'(7 - i), 4'(i), 24'h0});
    end
    // reset calibration is unity gain and zero offset, so samples up to 7FFF pass straight through and larger ones clamp at 7FFF
    run = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    run = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    rd(`ECC_IDX_MON_ENC, {eexp[2], eexp[0]});
    foreach (tbl[k]) begin
      for (int g = 0; g < 3; g++) begin
        seed = nxt(seed);
        cal[g][15:0] = seed;
        seed = nxt(seed);
        cal[g][31:16] = (k == 0) ? seed : {{8{seed[7]}}, seed[7:0]};
        wrrd(`ECC_IDX_CAL0 + 7'(g), cal[g]);
      end
      sel = tbl[k];
      wr(`ECC_IDX_SEL, sel);
      rd(`ECC_IDX_SEL, sel);
      run = 1'b1;
      repeat (40) @(negedge sys_clk_i);
      run = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      rd(`ECC_IDX_MON_ENC, {eexp[2], eexp[0]});
      wr(`ECC_IDX_MON_IUW, ~{cexp[2], cexp[0]});
      wr(`ECC_IDX_MON_IV, 32'hFFFF_FFFF);
      wr(`ECC_IDX_MON_ENC, 32'hFFFF_FFFF);
      rd(`ECC_IDX_MON_IUW, {cexp[2], cexp[0]});
      rd(`ECC_IDX_MON_IV, {16'h0, cexp[1]});
      rd(`ECC_IDX_MON_ENC, {eexp[2], eexp[0]});
      chk({fu, fw}, {cexp[0], cexp[2]});
    end
    conclude();
  end
endmodule
